// >>> hw/pcsbr_regs.v
// pcsbr_regs.v - apb register slice: per-port clocking select, boot clock-mode status,
// and secondary bus reset delay timer.
// assumes a 20 mhz core clock, fundamental reset on RST_B_I, boot pins static around reset.
// assumes the apb master holds each request until pready, as the protocol asks.
// a wait already running keeps the delay it started with; a new request takes the current one.
`timescale 1ns/1ps
`default_nettype none
`include "pcsbr_defines.vh"

// Behaviour
// RULE_01 - sixteen 2-bit port clock fields, port n bits 2n+1:2n
// RULE_02 - each field drives its port clocking output
// RULE_03 - 0 global, 1 local, 2/3 reserved
// RULE_04 - clock select writable at any time
// RULE_05 - clock fields initialised from boot pins
// RULE_06 - boot clock mode sampled, readable read-only
// RULE_07 - 16-bit microsecond delay before bus reset
// RULE_08 - delay resets to zero, zero means immediate
// RULE_09 - software should not lower the delay
// RULE_10 - delay upper half reads zero, ignores writes
// RULE_11 - values kept across non-fundamental resets
module pcsbr_regs (
  input  wire        CLK_I,
  input  wire        RST_B_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  input  wire [3:0]  PSTRB_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire [2:0]  BOOT_CLK_MODE_I,
  input  wire        SBR_REQUEST_I,
  output reg  [15:0] PORT_LOCAL_CLK_O,
  output reg  [15:0] PORT_GLOBAL_CLK_O,
  output reg         SBR_START_O,
  output reg         SBR_PENDING_O
);

  // ====================================================================
  // declarations
  reg [2:0]   boot_meta_reg;
  reg [2:0]   boot_sync_reg;
  reg [1:0]   init_cnt_reg;
  reg [2:0]   boot_clk_select_reg;
  reg [31:0]  clk_select_reg;
  reg [15:0]  bus_reset_delay_us_reg;
  reg         req_meta_reg;
  reg         req_sync_reg;
  reg         req_old_reg;
  wire        timer_fire;
  wire        timer_busy;
  wire        wr_access;
  wire        rd_access;
  wire        sbr_start_pulse;
  wire [31:0] dly_wr_word;
  reg  [31:0] rd_data_next;
  reg         rd_err_next;
  integer     i;

  // expand a 3-bit boot clock mode into the 32-bit per-port initial value
  // any nonzero boot code means local clocking; only zero keeps ports global
  function [31:0] boot_to_ports;
    input [2:0] mode;
    integer     k;
    begin
      boot_to_ports = 32'h0000_0000;
      for (k = 0; k < `PCSBR_PORTS; k = k + 1) begin
        boot_to_ports[2*k +: 2] = (mode == 3'h0) ? `PCSBR_MODE_GLOBAL : `PCSBR_MODE_LOCAL;
      end
    end
  endfunction

  // apply byte strobes to a stored word
  // lanes whose strobe is low keep the stored byte
  function [31:0] strobe_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer      b;
    begin
      strobe_merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          strobe_merge[8*b +: 8] = new_val[8*b +: 8];
        end
      end
    end
  endfunction

  // ====================================================================
  // apb decode; a write commits only on the edge that samples pready high,
  // so a master that lingers in the access phase cannot write twice;
  // read data is fetched in setup so it stands through the access cycle
  assign wr_access = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  assign rd_access = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  // only the low half of the delay word is storage, the upper lanes fall away
  assign dly_wr_word = strobe_merge({16'h0000, bus_reset_delay_us_reg}, PWDATA_I, PSTRB_I);

  // ====================================================================
  // boot pin synchroniser; pins come from outside so two flops first
  // the request is edge detected behind the second flop, so a held level starts one wait only
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      boot_meta_reg <= 3'h0;
      boot_sync_reg <= 3'h0;
      req_meta_reg  <= 1'b0;
      req_sync_reg  <= 1'b0;
      req_old_reg   <= 1'b0;
    end else begin
      boot_meta_reg <= BOOT_CLK_MODE_I;
      boot_sync_reg <= boot_meta_reg;
      req_meta_reg  <= SBR_REQUEST_I;
      req_sync_reg  <= req_meta_reg;
      req_old_reg   <= req_sync_reg;
    end
  end

  assign sbr_start_pulse = req_sync_reg & ~req_old_reg;

  // ====================================================================
  // registers; RST_B_I is the fundamental reset, nothing else clears them
  // the boot value is captured by a clock edge after release, since an async
  // reset may only load constants; counter lets the synchroniser settle first
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin // RULE_11
      init_cnt_reg           <= 2'h0;
      boot_clk_select_reg    <= 3'h0;
      clk_select_reg         <= `PCSBR_CLK_SELECT_RST;
      bus_reset_delay_us_reg <= `PCSBR_DELAY_RST; // RULE_08
    end else begin
      if (init_cnt_reg != 2'h3) begin
        init_cnt_reg <= init_cnt_reg + 2'h1;
        if (init_cnt_reg == 2'h2) begin
          boot_clk_select_reg <= boot_sync_reg; // RULE_06
          clk_select_reg      <= boot_to_ports(boot_sync_reg); // RULE_05
        end
      end
      if (wr_access && PADDR_I == `PCSBR_OFS_CLK_SELECT) begin
        clk_select_reg <= strobe_merge(clk_select_reg, PWDATA_I, PSTRB_I); // RULE_04
      end
      if (wr_access && PADDR_I == `PCSBR_OFS_RST_DELAY) begin
        bus_reset_delay_us_reg <= dly_wr_word[15:0]; // RULE_10
      end
    end
  end

  // ====================================================================
  // read mux; unmapped addresses answer zero with pslverr
  // reserved port codes read back as written; all 32 select bits are storage
  always @* begin
    rd_data_next = 32'h0000_0000;
    rd_err_next  = 1'b0;
    case (PADDR_I)
      `PCSBR_OFS_CLK_SELECT:  rd_data_next = clk_select_reg; // RULE_01
      `PCSBR_OFS_RST_DELAY:   rd_data_next = {16'h0000, bus_reset_delay_us_reg}; // RULE_10
      `PCSBR_OFS_BOOT_STATUS: rd_data_next[`PCSBR_BOOT_LSB +: 3] = boot_clk_select_reg; // RULE_06
      default:                rd_err_next  = 1'b1;
    endcase
  end

  // ====================================================================
  // pslverr follows the address only; a write to the status word is dropped quietly
  // apb answer: data registered in setup, pready high in the access phase,
  // so every transfer takes exactly two cycles
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
        PSLVERR_O <= rd_err_next;
        if (rd_access) begin
          PRDATA_O <= rd_data_next;
        end
      end else begin
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // ====================================================================
  // port clock decode; reserved codes drive neither output
  // a stray reserved code parks the port rather than picking a wrong clock
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      PORT_LOCAL_CLK_O  <= 16'h0000;
      PORT_GLOBAL_CLK_O <= 16'h0000;
    end else begin
      for (i = 0; i < `PCSBR_PORTS; i = i + 1) begin
        PORT_GLOBAL_CLK_O[i] <= (clk_select_reg[2*i +: 2] == `PCSBR_MODE_GLOBAL); // RULE_02 RULE_03
        PORT_LOCAL_CLK_O[i]  <= (clk_select_reg[2*i +: 2] == `PCSBR_MODE_LOCAL); // RULE_03
      end
    end
  end

  // ====================================================================
  // bus reset delay; software lowering the delay mid-wait is its own risk
  // the prescaler counts core clocks, so the microsecond holds only at 20 mhz
  pcsbr_delay_timer u_timer (
    .clk_i      (CLK_I),
    .rst_b_i    (RST_B_I),
    .start_i    (sbr_start_pulse),
    .delay_us_i (bus_reset_delay_us_reg),
    .fire_o     (timer_fire),
    .busy_o     (timer_busy)
  );

  // registered copies, so every output of the slice leaves a flop
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SBR_START_O   <= 1'b0;
      SBR_PENDING_O <= 1'b0;
    end else begin
      SBR_START_O   <= timer_fire; // RULE_07
      SBR_PENDING_O <= timer_busy;
    end
  end

endmodule // pcsbr_regs
`default_nettype wire

// >>> hw/pcsbr_defines.vh
// pcsbr_defines.vh - register offsets, field positions, reset values and timing counts
// for the port clocking select and bus reset delay register slice.
// assumes inclusion by its bare name from the design files under hw/.
`ifndef PCSBR_DEFINES_VH
`define PCSBR_DEFINES_VH

// ====================================================================
// register byte offsets (apb, one aligned 32-bit word each)
`define PCSBR_ADDR_W            8
`define PCSBR_OFS_CLK_SELECT    8'h08
`define PCSBR_OFS_RST_DELAY     8'h8c
`define PCSBR_OFS_BOOT_STATUS   8'h04

// ====================================================================
// field layout
`define PCSBR_PORTS             16
`define PCSBR_MODE_W            2
`define PCSBR_MODE_GLOBAL       2'h0
`define PCSBR_MODE_LOCAL        2'h1
`define PCSBR_BOOT_W            3
`define PCSBR_BOOT_LSB          21
`define PCSBR_DELAY_W           16

// ====================================================================
// reset values
`define PCSBR_DELAY_RST         16'h0000
`define PCSBR_CLK_SELECT_RST    32'h0000_0000

// ====================================================================
// timing: one microsecond in core clocks at 20 mhz
`define PCSBR_CLK_MHZ           20
`define PCSBR_US_NS             1000
`define PCSBR_CLK_NS            50
`define PCSBR_CYC_PER_US        (`PCSBR_US_NS / `PCSBR_CLK_NS)
// last prescaler count of a microsecond (cycles per us minus one), sized for the 5-bit prescaler
`define PCSBR_PRE_LAST          5'h13

`endif

// >>> hw/pcsbr_delay_timer.v
// pcsbr_delay_timer.v - microsecond delay between a bus reset request and its start.
// assumes a single core clock at 20 mhz and a delay value that is held stable by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "pcsbr_defines.vh"

module pcsbr_delay_timer (
  input  wire                      clk_i,
  input  wire                      rst_b_i,
  input  wire                      start_i,
  input  wire [`PCSBR_DELAY_W-1:0] delay_us_i,
  output reg                       fire_o,
  output reg                       busy_o
);

  // ====================================================================
  // counters
  reg [4:0]                 pre_reg;
  reg [`PCSBR_DELAY_W-1:0]  us_reg;

  // a fresh request while busy restarts the wait: the latest request wins
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_reg <= 5'h00;
      us_reg  <= 16'h0000;
      fire_o  <= 1'b0;
      busy_o  <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (start_i) begin
        if (delay_us_i == 16'h0000) begin
          fire_o <= 1'b1; // RULE_08
          busy_o <= 1'b0;
        end else begin
          busy_o  <= 1'b1; // RULE_07
          us_reg  <= delay_us_i;
          pre_reg <= `PCSBR_PRE_LAST;
        end
      end else if (busy_o) begin
        if (pre_reg != 5'h00) begin
          pre_reg <= pre_reg - 5'h01;
        end else if (us_reg == 16'h0001) begin
          fire_o <= 1'b1; // RULE_07
          busy_o <= 1'b0;
        end else begin
          us_reg  <= us_reg - 16'h0001;
          pre_reg <= `PCSBR_PRE_LAST;
        end
      end
    end
  end

endmodule // pcsbr_delay_timer
`default_nettype wire

// >>> verification/pcsbr_regs_chk.sv
// pcsbr_regs_chk - port checks of the clock select and bus reset delay slice
// assumes boot pins stay static while RST_B_I is high
`timescale 1ns/1ps
`default_nettype none
// ====================
// checker
module pcsbr_regs_chk (
  input wire logic        CLK_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O,
  input wire logic        SBR_REQUEST_I, SBR_START_O, SBR_PENDING_O,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I, PRDATA_O,
  input wire logic [3:0]  PSTRB_I,
  input wire logic [2:0]  BOOT_CLK_MODE_I,
  input wire logic [15:0] PORT_LOCAL_CLK_O, PORT_GLOBAL_CLK_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic [15:0] dly_reg;
  int          pend_cnt;
  wire         acc = PSEL_I && PENABLE_I && PREADY_O;
  wire         rd  = acc && !PWRITE_I;
  function automatic logic [15:0] sel_map(input logic [31:0] w, input logic [1:0] c);
    for (int n = 0; n < 16; n++) sel_map[n] = (w[2*n +: 2] == c);
  endfunction
  // shadow of the delay word by lanes, and the length of the current wait
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      dly_reg  <= 16'h0000;
      pend_cnt <= 0;
    end else begin
      if (acc && PWRITE_I && PADDR_I == 8'h8c && PSTRB_I[0]) dly_reg[7:0] <= PWDATA_I[7:0];
      if (acc && PWRITE_I && PADDR_I == 8'h8c && PSTRB_I[1]) dly_reg[15:8] <= PWDATA_I[15:8];
      pend_cnt <= SBR_PENDING_O ? pend_cnt + 1 : 0;
    end
  end
  a_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready");
  a_mode_map: assert property (acc && PWRITE_I && PADDR_I == 8'h08 && PSTRB_I == 4'hf |-> ##2
    PORT_LOCAL_CLK_O == sel_map($past(PWDATA_I, 2), 2'h1) && PORT_GLOBAL_CLK_O == sel_map($past(PWDATA_I, 2), 2'h0))
    else $error("port clock outputs wrong");
  a_mode_excl: assert property ((PORT_LOCAL_CLK_O & PORT_GLOBAL_CLK_O) == 16'h0000) else $error("both modes");
  a_boot_stat: assert property (rd && PADDR_I == 8'h04 |-> PRDATA_O[23:21] == BOOT_CLK_MODE_I) else $error("boot");
  a_dly_read: assert property (rd && PADDR_I == 8'h8c |-> PRDATA_O == {16'h0000, dly_reg}) else $error("delay");
  a_zero_start: assert property ($rose(SBR_REQUEST_I) && dly_reg == 16'h0000 |-> ##[3:8] SBR_START_O)
    else $error("zero delay start late");
  a_dly_bound: assert property (pend_cnt <= dly_reg * 20 + 6) else $error("wait too long");
  a_dly_floor: assert property ($fell(SBR_PENDING_O) |-> pend_cnt + 4 >= dly_reg * 20) else $error("wait short");
endmodule // pcsbr_regs_chk
bind pcsbr_regs pcsbr_regs_chk pcsbr_regs_chk_i (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PREADY_O(PREADY_O), .SBR_REQUEST_I(SBR_REQUEST_I),
  .SBR_START_O(SBR_START_O), .SBR_PENDING_O(SBR_PENDING_O), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PSTRB_I(PSTRB_I), .BOOT_CLK_MODE_I(BOOT_CLK_MODE_I),
  .PORT_LOCAL_CLK_O(PORT_LOCAL_CLK_O), .PORT_GLOBAL_CLK_O(PORT_GLOBAL_CLK_O));
`default_nettype wire

// >>> verification/pcsbr_regs_tb_top.sv
// pcsbr_regs_tb_top - random and corner apb traffic, boot values, bus reset timing
// assumes the slice answers each transfer within sixteen access cycles
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench
module pcsbr_regs_tb_top;
  logic        clk = 0, rst_b = 0, sel = 0, en = 0, wr = 0, req = 0, e;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, w;
  logic [3:0]  ps = 4'hf;
  logic [2:0]  boot = 3'h0;
  wire  [31:0] prdata;
  wire  [15:0] loc, glb;
  wire         rdy, err, start, pend;
  int          error_cnt = 0, n_tests = 0, seed = 32'h3c0c, k, d;
  pcsbr_regs pcsbr_regs_i (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(sel), .PENABLE_I(en), .PWRITE_I(wr),
    .PADDR_I(adr), .PWDATA_I(wd), .PSTRB_I(ps), .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err),
    .BOOT_CLK_MODE_I(boot), .SBR_REQUEST_I(req), .PORT_LOCAL_CLK_O(loc), .PORT_GLOBAL_CLK_O(glb),
    .SBR_START_O(start), .SBR_PENDING_O(pend));
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] sel_map(input logic [31:0] v, input logic [1:0] c);
    for (int n = 0; n < 16; n++) sel_map[n] = (v[2*n +: 2] == c);
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", nm, x, s);
    end
  endtask
  // request is left up so a following transfer can go back to back;
  // pready, read data and the error flag are all taken at the edge that ends the access
  task automatic apb(input logic w_i, input logic [7:0] a, input logic [31:0] dat);
    sel <= 1;
    en <= 0;
    wr <= w_i;
    adr <= a;
    wd <= dat;
    @(posedge clk) en <= 1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    rd = prdata;
    e = err;
    if (k == 16) begin
      error_cnt++;
      stop_test;
    end
  endtask
  task automatic idle(input int n);
    sel <= 0;
    en <= 0;
    repeat (n) @(posedge clk);
  endtask
  task automatic boot_up(input logic [2:0] b);
    rst_b <= 0;
    boot <= b;
    repeat (8) @(posedge clk);
    rst_b <= 1;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    // zero and a random nonzero boot value
    for (d = 0; d < 2; d++) begin
      boot_up(d ? 3'h1 + 3'({$random(seed)} % 7) : 3'h0);
      apb(0, 8'h04, 32'h0);
      chk("boot", rd[23:21], boot);
      apb(0, 8'h08, 32'h0);
      chk("select", rd, d ? 32'h5555_5555 : 32'h0);
      apb(0, 8'h8c, 32'h0);
      chk("delay", rd, 32'h0);
      idle(2);
      chk("local", loc, d ? 16'hffff : 16'h0);
    end
    $display("test boot done");
    // one word with all four codes, then random words
    for (d = 0; d < 8; d++) begin
      w = d ? $random(seed) : 32'he4e4_e4e4;
      apb(1, 8'h08, w);
      apb(0, 8'h08, 32'h0);
      chk("readback", rd, w);
      idle(3);
      chk("local", loc, sel_map(w, 2'h1));
      chk("global", glb, sel_map(w, 2'h0));
    end
    apb(1, 8'h04, 32'hffff_ffff);
    apb(0, 8'h04, 32'h0);
    chk("boot ro", rd[23:21], boot);
    apb(0, 8'h10, 32'h0);
    chk("unmapped err", e, 32'h1);
    $display("test select done");
    // delays 0, 1, 3 us: only ever raised
    for (d = 0; d < 3; d++) begin
      apb(1, 8'h8c, d * (d + 1) / 2);
      idle(1);
      req <= 1;
      for (k = 0; k < 200 && start !== 1'b1; k++) @(negedge clk);
      chk("sbr wait", k >= d * (d + 1) * 10 && k <= d * (d + 1) * 10 + 12, 32'h1);
      @(posedge clk) req <= 0;
      idle(2);
    end
    // lanes 0, 2 and 3 strobed: the low byte lands, the upper half is dropped
    ps <= 4'hd;
    apb(1, 8'h8c, 32'hffff_ffff);
    ps <= 4'hf;
    idle(20);
    apb(0, 8'h8c, 32'h0);
    chk("delay lanes", rd, 32'h0000_00ff);
    $display("test delay done");
    stop_test;
  end
endmodule // pcsbr_regs_tb_top
`default_nettype wire
